// *** logic/usbev_ep_event.sv ***
// Event status bits of one data endpoint
`timescale 1ns/1ps
`default_nettype none
module usbev_ep_event
   import usbev_pkg::*;
(
   input  wire logic             core_clk,
   input  wire logic             resetn,
   input  wire logic [EPC_W-1:0] ctl,
   input  wire logic             stat_wr,
   input  wire logic [EPS_W-1:0] stat_wdata,
   input  wire logic             pkt_short,
   input  wire logic             pkt_zero,
   input  wire logic             side_switch,
   input  wire logic             nak_in,
   input  wire logic             overrun,
   input  wire logic             pkt_ready,
   output logic [EPS_W-1:0]      stat_q,
   output logic                  event_q
);
   logic             hold_q;
   logic             hold_d;
   logic             short_rx;
   logic             short_fire;
   logic [EPS_W-1:0] set_v;
   logic [EPS_W-1:0] clr_v;
   logic [EPS_W-1:0] stat_d;
   logic [EPS_W-1:0] en_v;

   assign short_rx   = ctl[EPC_RX_DIR] & (pkt_short | pkt_zero);
   assign short_fire = ctl[EPC_MULTI] ? (side_switch & (hold_q | short_rx))
                                      : short_rx;
   assign hold_d     = ctl[EPC_MULTI] & (short_rx | hold_q) & ~short_fire;
   assign set_v      = {pkt_ready, overrun, nak_in, short_fire};
   assign clr_v      = stat_wr ? stat_wdata : '0;
   assign stat_d     = (stat_q & ~clr_v) | set_v;
   assign en_v       = {ctl[EPC_RDY_EN], ctl[EPC_OVR_EN], ctl[EPC_NAK_EN], ctl[EPC_SHORT_EN]};

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         stat_q <= '0;
         hold_q <= 1'b0;
      end else begin
         stat_q <= stat_d;
         hold_q <= hold_d;
      end
   end

   // Event summary stays up while any enabled source is uncleared
   assign event_q = |(stat_q & en_v);
endmodule
`default_nettype wire

// *** logic/usbev_pkg.sv ***
// Register map, field positions and codes of the USB device event block
package usbev_pkg;
   localparam int        USBEV_AW       = 8;
   localparam int        USBEV_DW       = 32;
   localparam logic [7:0] OFS_GIE       = 8'h00;
   localparam logic [7:0] OFS_GIS       = 8'h04;
   localparam logic [7:0] OFS_E0_CTL    = 8'h08;
   localparam logic [7:0] OFS_E0_STAT   = 8'h0C;
   localparam logic [7:0] OFS_EP_BASE   = 8'h10;
   localparam logic [7:0] OFS_EP_STRIDE = 8'h08;
   localparam logic [7:0] OFS_EP_STAT   = 8'h04;
   // Endpoint control fields
   localparam int EPC_SHORT_EN = 0;
   localparam int EPC_NAK_EN   = 1;
   localparam int EPC_OVR_EN   = 2;
   localparam int EPC_RDY_EN   = 3;
   localparam int EPC_RX_DIR   = 4;
   localparam int EPC_MULTI    = 5;
   localparam int EPC_W        = 6;
   // Endpoint status fields
   localparam int EPS_SHORT    = 0;
   localparam int EPS_NAK      = 1;
   localparam int EPS_OVR      = 2;
   localparam int EPS_RDY      = 3;
   localparam int EPS_W        = 4;
   // Control endpoint fields
   localparam int E0C_CFG_EN   = 0;
   localparam int E0C_STS_EN   = 1;
   localparam int E0C_W        = 2;
   localparam int E0S_CFG      = 0;
   localparam int E0S_IS_INTF  = 1;
   localparam int E0S_STS      = 2;
   localparam int E0S_CFG_LSB  = 8;
   localparam int E0S_INTF_LSB = 16;
   localparam int E0S_ALT_LSB  = 24;
   // Reset values
   localparam logic [EPC_W-1:0] EPC_RESET = '0;
   localparam logic [E0C_W-1:0] E0C_RESET = '0;
   // Standard request codes
   localparam logic [7:0] REQ_SET_CONFIG = 8'h09;
   localparam logic [7:0] REQ_SET_INTF   = 8'h0B;
   typedef enum logic {USBEV_BUS_WAIT, USBEV_BUS_ANS} usbev_bus_t;
endpackage

// *** logic/usbev_top.sv ***
// USB device event and interrupt block with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
module usbev_top
   import usbev_pkg::*;
#(
   parameter int NUM_EP = 4
)
(
   input  wire logic                 core_clk,
   input  wire logic                 resetn,
   input  wire logic [USBEV_AW-1:0]  avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [USBEV_DW-1:0]  avs_writedata,
   output logic [USBEV_DW-1:0]       avs_readdata,
   output logic                      avs_waitrequest,
   input  wire logic [NUM_EP-1:0]    ep_pkt_short,
   input  wire logic [NUM_EP-1:0]    ep_pkt_zero,
   input  wire logic [NUM_EP-1:0]    ep_side_switch,
   input  wire logic [NUM_EP-1:0]    ep_nak_in,
   input  wire logic [NUM_EP-1:0]    ep_overrun,
   input  wire logic [NUM_EP-1:0]    ep_pkt_ready,
   input  wire logic                 setup_rcvd,
   input  wire logic [7:0]           setup_request,
   input  wire logic [15:0]          setup_value,
   input  wire logic [15:0]          setup_index,
   input  wire logic                 hs_done,
   input  wire logic                 status_enter,
   input  wire logic                 ctl_auto,
   input  wire logic                 status_token,
   output logic                      hs_valid,
   output logic                      hs_nak,
   output logic                      irq_out_n
);
   // Enable and status words hold one bit per endpoint above bit 0
   if (NUM_EP < 1 || NUM_EP > 8) begin : g_bad_num_ep
      $error("NUM_EP must be 1 to 8");
   end

   function automatic logic ep_hit(input logic [USBEV_AW-1:0] addr,
                                   input int n,
                                   input logic [7:0] sub);
      logic [7:0] base;
      base   = OFS_EP_BASE + 8'(n) * OFS_EP_STRIDE + sub;
      ep_hit = (addr == base);
   endfunction

   // Bus slave state
   usbev_bus_t              bus_q;
   usbev_bus_t              bus_d;
   logic [USBEV_DW-1:0]     rdata_q;
   logic [USBEV_DW-1:0]     rdata_d;
   logic                    wait_q;
   logic                    req;
   logic                    wr_go;

   // Registers
   logic [NUM_EP-1:0]       gie_q;
   logic [NUM_EP-1:0]       gie_d;
   logic [E0C_W-1:0]        e0_ctl_q;
   logic [E0C_W-1:0]        e0_ctl_d;
   logic                    cfg_ev_q;
   logic                    cfg_ev_d;
   logic                    is_intf_q;
   logic [7:0]              cfg_val_q;
   logic [7:0]              intf_val_q;
   logic [7:0]              alt_val_q;
   logic                    sts_ev_q;
   logic                    sts_ev_d;
   logic [EPC_W-1:0]        ep_ctl_q [NUM_EP];
   logic [EPS_W-1:0]        ep_stat  [NUM_EP];
   logic [NUM_EP-1:0]       ep_event;
   logic [NUM_EP-1:0]       ep_ctl_wr;
   logic [NUM_EP-1:0]       ep_stat_wr;

   // Setup tracking
   logic                    ack_wait_q;
   logic [7:0]              req_q;
   logic [15:0]             val_q;
   logic [15:0]             idx_q;
   logic                    hs_valid_q;
   logic                    hs_nak_q;
   logic                    irq_n_q;

   // Decode
   logic                    sel_gie;
   logic                    gie_wr;
   logic                    sel_e0_ctl;
   logic                    sel_e0_stat;
   logic                    cfg_fire;
   logic                    sts_fire;
   logic                    cfg_clr;
   logic                    sts_clr;
   logic                    is_cfg_req;
   logic                    is_intf_req;
   logic [USBEV_DW-1:0]     gis_word;
   logic [USBEV_DW-1:0]     e0_stat_word;
   logic                    e0_pending;
   logic                    irq_any;

   assign req         = avs_read | avs_write;
   assign wr_go       = avs_write & ~wait_q;
   assign sel_gie     = (avs_address == OFS_GIE);
   assign sel_e0_ctl  = (avs_address == OFS_E0_CTL);
   assign sel_e0_stat = (avs_address == OFS_E0_STAT);

   genvar g;
   generate
      for (g = 0; g < NUM_EP; g++) begin : g_ep
         assign ep_ctl_wr[g]  = wr_go & ep_hit(avs_address, g, 8'h00);
         assign ep_stat_wr[g] = wr_go & ep_hit(avs_address, g, OFS_EP_STAT);

         always_ff @(posedge core_clk or negedge resetn) begin
            if (!resetn) begin
               ep_ctl_q[g] <= EPC_RESET;
            end else if (ep_ctl_wr[g]) begin
               ep_ctl_q[g] <= avs_writedata[EPC_W-1:0];
            end
         end

         usbev_ep_event u_ep (
            .core_clk    (core_clk),
            .resetn      (resetn),
            .ctl         (ep_ctl_q[g]),
            .stat_wr     (ep_stat_wr[g]),
            .stat_wdata  (avs_writedata[EPS_W-1:0]),
            .pkt_short   (ep_pkt_short[g]),
            .pkt_zero    (ep_pkt_zero[g]),
            .side_switch (ep_side_switch[g]),
            .nak_in      (ep_nak_in[g]),
            .overrun     (ep_overrun[g]),
            .pkt_ready   (ep_pkt_ready[g]),
            .stat_q      (ep_stat[g]),
            .event_q     (ep_event[g])
         );
      end
   endgenerate

   // Setup stage and status stage events
   assign is_cfg_req  = (req_q == REQ_SET_CONFIG);
   assign is_intf_req = (req_q == REQ_SET_INTF);
   assign cfg_fire    = ack_wait_q & hs_done & (is_cfg_req | is_intf_req);
   assign sts_fire    = status_enter & ~ctl_auto & e0_ctl_q[E0C_STS_EN];
   assign cfg_clr     = wr_go & sel_e0_stat & avs_writedata[E0S_CFG];
   assign sts_clr     = wr_go & sel_e0_stat & avs_writedata[E0S_STS];
   assign cfg_ev_d    = cfg_fire | (cfg_ev_q & ~cfg_clr);
   assign sts_ev_d    = sts_fire | (sts_ev_q & ~sts_clr);

   always_comb begin
      e0_ctl_d = e0_ctl_q;
      if (wr_go && sel_e0_ctl) begin
         e0_ctl_d = avs_writedata[E0C_W-1:0];
      end
      if (sts_clr) begin
         e0_ctl_d[E0C_STS_EN] = 1'b0;
      end
   end

   assign gie_wr = wr_go & sel_gie;
   assign gie_d  = gie_wr ? avs_writedata[NUM_EP:1] : gie_q;

   // Endpoint event enables
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         gie_q <= '0;
      end else begin
         gie_q <= gie_d;
      end
   end

   // Control endpoint enables
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         e0_ctl_q <= E0C_RESET;
      end else begin
         e0_ctl_q <= e0_ctl_d;
      end
   end

   // Sticky control endpoint events; a set wins over a clear in the same cycle
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         cfg_ev_q <= 1'b0;
         sts_ev_q <= 1'b0;
      end else begin
         cfg_ev_q <= cfg_ev_d;
         sts_ev_q <= sts_ev_d;
      end
   end

   // Request values captured when the response event fires
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         is_intf_q  <= 1'b0;
         cfg_val_q  <= '0;
         intf_val_q <= '0;
         alt_val_q  <= '0;
      end else if (cfg_fire) begin
         is_intf_q <= is_intf_req;
         if (is_cfg_req) begin
            cfg_val_q <= val_q[7:0];
         end else begin
            intf_val_q <= idx_q[7:0];
            alt_val_q  <= val_q[7:0];
         end
      end
   end

   // Setup fields held until the next setup packet arrives
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         req_q      <= '0;
         val_q      <= '0;
         idx_q      <= '0;
         ack_wait_q <= 1'b0;
      end else if (setup_rcvd) begin
         req_q      <= setup_request;
         val_q      <= setup_value;
         idx_q      <= setup_index;
         ack_wait_q <= 1'b1;
      end else if (hs_done) begin
         ack_wait_q <= 1'b0;
      end
   end

   // Handshake answers: setup always ACK, status token NAK while pending
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         hs_valid_q <= 1'b0;
         hs_nak_q   <= 1'b0;
      end else if (setup_rcvd) begin
         hs_valid_q <= 1'b1;
         hs_nak_q   <= 1'b0;
      end else if (status_token) begin
         hs_valid_q <= 1'b1;
         hs_nak_q   <= sts_ev_q;
      end else begin
         hs_valid_q <= 1'b0;
         hs_nak_q   <= 1'b0;
      end
   end

   // Status words
   assign e0_pending = (cfg_ev_q & e0_ctl_q[E0C_CFG_EN]) | sts_ev_q;
   assign gis_word   = USBEV_DW'({(ep_event & gie_q), e0_pending});
   assign e0_stat_word = {alt_val_q, intf_val_q, cfg_val_q, 5'h00,
                          sts_ev_q, is_intf_q, cfg_ev_q};
   assign irq_any    = |gis_word;

   // Pin follows the summary one cycle later, straight from a flip-flop
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         irq_n_q <= 1'b1;
      end else begin
         irq_n_q <= ~irq_any;
      end
   end

   // Read mux
   always_comb begin
      rdata_d = '0;
      if (sel_gie) begin
         rdata_d = USBEV_DW'({gie_q, 1'b0});
      end else if (avs_address == OFS_GIS) begin
         rdata_d = gis_word;
      end else if (sel_e0_ctl) begin
         rdata_d = USBEV_DW'(e0_ctl_q);
      end else if (sel_e0_stat) begin
         rdata_d = e0_stat_word;
      end
      for (int i = 0; i < NUM_EP; i++) begin
         if (ep_hit(avs_address, i, 8'h00)) begin
            rdata_d = USBEV_DW'(ep_ctl_q[i]);
         end
         if (ep_hit(avs_address, i, OFS_EP_STAT)) begin
            rdata_d = USBEV_DW'(ep_stat[i]);
         end
      end
   end

   // Slave: one wait cycle, then answer with waitrequest low
   always_comb begin
      bus_d = bus_q;
      unique case (bus_q)
         USBEV_BUS_WAIT: begin
            if (req) begin
               bus_d = USBEV_BUS_ANS;
            end
         end
         USBEV_BUS_ANS: begin
            bus_d = USBEV_BUS_WAIT;
         end
      endcase
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         bus_q  <= USBEV_BUS_WAIT;
         wait_q <= 1'b1;
      end else begin
         bus_q  <= bus_d;
         wait_q <= (bus_d != USBEV_BUS_ANS);
      end
   end

   // Read data registered every cycle, so it already stands in the answer cycle
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_q <= '0;
      end else begin
         rdata_q <= rdata_d;
      end
   end

   assign avs_readdata    = rdata_q;
   assign avs_waitrequest = wait_q;
   assign hs_valid        = hs_valid_q;
   assign hs_nak          = hs_nak_q;
   assign irq_out_n       = irq_n_q;
endmodule
`default_nettype wire

// *** tb/usbev_link_model.sv ***
// Behavioural USB host and link side of the event block
`timescale 1ns/1ps
`default_nettype none
module usbev_link_model (
   input  wire logic   core_clk,
   input  wire logic   hs_valid,
   input  wire logic   hs_nak,
   output logic        setup_rcvd,
   output logic [7:0]  setup_request,
   output logic [15:0] setup_value,
   output logic [15:0] setup_index,
   output logic        hs_done,
   output logic        status_enter,
   output logic        ctl_auto,
   output logic        status_token,
   output logic        last_nak
);
   int dly = 2;
   int cnt = 0;
   initial begin
      {setup_rcvd, setup_request, setup_value, setup_index} = '0;
      {hs_done, status_enter, ctl_auto, status_token, last_nak} = '0;
   end
   // Handshake goes out on the wire, completion reported after dly cycles
   always @(posedge core_clk) begin
      hs_done <= (cnt == 1);
      if (hs_valid) begin
         last_nak <= hs_nak;
         cnt <= dly;
      end else if (cnt != 0) begin
         cnt <= cnt - 1;
      end
   end
   task automatic setup(input logic [7:0] r, input logic [15:0] v, x);
      setup_request <= r;
      setup_value <= v;
      setup_index <= x;
      setup_rcvd <= 1'b1;
      @(posedge core_clk);
      setup_rcvd <= 1'b0;
      setup_value <= ~v;
      setup_index <= ~x;
      @(posedge core_clk);
   endtask
   task automatic enter(input logic a);
      ctl_auto <= a;
      status_enter <= 1'b1;
      @(posedge core_clk);
      status_enter <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic token();
      status_token <= 1'b1;
      @(posedge core_clk);
      status_token <= 1'b0;
      repeat (2) @(posedge core_clk);
   endtask
endmodule
`default_nettype wire

// *** tb/usbev_top_sva.sv ***
// Port assertions of the USB device event block
`timescale 1ns/1ps
`default_nettype none
module usbev_top_sva #(
   parameter int NUM_EP = 4
)
(
   input wire logic              core_clk,
   input wire logic              resetn,
   input wire logic              avs_read,
   input wire logic              avs_write,
   input wire logic              avs_waitrequest,
   input wire logic [NUM_EP-1:0] ep_pkt_short,
   input wire logic [NUM_EP-1:0] ep_pkt_zero,
   input wire logic [NUM_EP-1:0] ep_side_switch,
   input wire logic [NUM_EP-1:0] ep_nak_in,
   input wire logic [NUM_EP-1:0] ep_overrun,
   input wire logic [NUM_EP-1:0] ep_pkt_ready,
   input wire logic              setup_rcvd,
   input wire logic              hs_done,
   input wire logic              status_enter,
   input wire logic              status_token,
   input wire logic              hs_valid,
   input wire logic              hs_nak,
   input wire logic              irq_out_n
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   wire logic ev_any = |{ep_pkt_short, ep_pkt_zero, ep_side_switch, ep_nak_in, ep_overrun, ep_pkt_ready};
   wire logic cause = ev_any | hs_done | status_enter | avs_write;
   sequence bus_req_s; (avs_read || avs_write) && avs_waitrequest; endsequence
   sequence answer_s; !avs_waitrequest ##1 avs_waitrequest; endsequence
   sequence ack_s; hs_valid && !hs_nak; endsequence
   bus_answer_a: assert property (bus_req_s |=> answer_s)
      else $error("bus answer late or long");
   bus_idle_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
      else $error("answer without request");
   setup_ack_a: assert property (setup_rcvd |=> ack_s)
      else $error("setup not acknowledged");
   token_ans_a: assert property (status_token && !setup_rcvd |=> hs_valid)
      else $error("status token not answered");
   hs_cause_a: assert property (hs_valid |-> $past(setup_rcvd || status_token))
      else $error("handshake without token");
   irq_fall_a: assert property ($fell(irq_out_n) |-> $past(cause, 2))
      else $error("interrupt without event");
   irq_rise_a: assert property ($rose(irq_out_n) |-> $past(avs_write && !avs_waitrequest, 2))
      else $error("interrupt dropped without write");
   irq_quiet_a: assert property ((!cause) [*3] |-> $stable(irq_out_n))
      else $error("interrupt moved while quiet");
endmodule
bind usbev_top usbev_top_sva #(.NUM_EP(NUM_EP)) u_sva (
   .core_clk(core_clk), .resetn(resetn), .avs_read(avs_read), .avs_write(avs_write),
   .avs_waitrequest(avs_waitrequest), .ep_pkt_short(ep_pkt_short), .ep_pkt_zero(ep_pkt_zero),
   .ep_side_switch(ep_side_switch), .ep_nak_in(ep_nak_in), .ep_overrun(ep_overrun),
   .ep_pkt_ready(ep_pkt_ready), .setup_rcvd(setup_rcvd), .hs_done(hs_done),
   .status_enter(status_enter), .status_token(status_token), .hs_valid(hs_valid),
   .hs_nak(hs_nak), .irq_out_n(irq_out_n)
);
`default_nettype wire

// *** tb/usbev_top_tb.sv ***
// Self-checking testbench of the USB device event block
`timescale 1ns/1ps
`default_nettype none
module usbev_top_tb
   import usbev_pkg::*;
;
   logic        core_clk = 1'b0;
   logic        resetn = 1'b0;
   logic [7:0]  avs_address = 8'h00;
   logic        avs_read = 1'b0;
   logic        avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0]  ep_pkt_short = 4'h0, ep_pkt_zero = 4'h0, ep_side_switch = 4'h0;
   logic [3:0]  ep_nak_in = 4'h0, ep_overrun = 4'h0, ep_pkt_ready = 4'h0;
   logic [31:0] d;
   int          num_errors = 0;
   int          checked = 0;
   wire logic [31:0] avs_readdata;
   wire logic        avs_waitrequest, hs_valid, hs_nak, irq_out_n, last_nak;
   wire logic        setup_rcvd, hs_done, status_enter, ctl_auto, status_token;
   wire logic [7:0]  setup_request;
   wire logic [15:0] setup_value, setup_index;
   // Endpoint 1 cases: event, control, global enable, expected irq and status
   logic [23:0] cs_ev [5] = '{24'h1, 24'h10, 24'h1, 24'h1, 24'h1};
   logic [31:0] cs_ctl [5] = '{32'h11, 32'h11, 32'h10, 32'h11, 32'h1};
   logic [31:0] cs_gie [5] = '{32'h2, 32'h2, 32'h2, 32'h0, 32'h2};
   logic [4:0]  cs_irq = 5'b11100;
   logic [4:0]  cs_st = 5'b01111;

   always #4 core_clk = ~core_clk;

   usbev_top #(.NUM_EP(4)) DUT (
      .core_clk(core_clk), .resetn(resetn), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .ep_pkt_short(ep_pkt_short), .ep_pkt_zero(ep_pkt_zero), .ep_side_switch(ep_side_switch),
      .ep_nak_in(ep_nak_in), .ep_overrun(ep_overrun), .ep_pkt_ready(ep_pkt_ready),
      .setup_rcvd(setup_rcvd), .setup_request(setup_request), .setup_value(setup_value),
      .setup_index(setup_index), .hs_done(hs_done), .status_enter(status_enter),
      .ctl_auto(ctl_auto), .status_token(status_token), .hs_valid(hs_valid),
      .hs_nak(hs_nak), .irq_out_n(irq_out_n)
   );
   usbev_link_model u_host (
      .core_clk(core_clk), .hs_valid(hs_valid), .hs_nak(hs_nak), .setup_rcvd(setup_rcvd),
      .setup_request(setup_request), .setup_value(setup_value), .setup_index(setup_index),
      .hs_done(hs_done), .status_enter(status_enter), .ctl_auto(ctl_auto),
      .status_token(status_token), .last_nak(last_nak)
   );

   task automatic chk(input string nm, input logic [31:0] s, e);
      checked++;
      if (s !== e) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
      avs_address <= a;
      avs_writedata <= v;
      avs_read <= !w;
      avs_write <= w;
      do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      @(posedge core_clk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      xfer(1'b1, a, v);
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] m, e);
      xfer(1'b0, a, 32'h0);
      chk($sformatf("reg %h", a), d & m, e);
   endtask
   task automatic ci(input logic e);
      repeat (6) @(posedge core_clk);
      chk("irq_out_n", {31'h0, irq_out_n}, {31'h0, e});
   endtask
   task automatic ev(input logic [23:0] v);
      {ep_pkt_ready, ep_overrun, ep_nak_in, ep_side_switch, ep_pkt_zero, ep_pkt_short} <= v;
      @(posedge core_clk);
      {ep_pkt_ready, ep_overrun, ep_nak_in, ep_side_switch, ep_pkt_zero, ep_pkt_short} <= 24'h0;
      @(posedge core_clk);
   endtask
   task automatic results();
      if (num_errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge core_clk);
      num_errors++;
      results();
   end

   initial begin
      repeat (12) @(posedge core_clk);
      resetn <= 1'b1;
      @(posedge core_clk);
      rc(OFS_E0_CTL, 32'hFFFFFFFF, 32'h0);
      wr(8'hF0, 32'hFFFFFFFF);
      rc(8'hF0, 32'hFFFFFFFF, 32'h0);
      for (int i = 0; i < 5; i++) begin
         wr(OFS_GIE, cs_gie[i]);
         wr(8'h10, cs_ctl[i]);
         ev(cs_ev[i]);
         ci(cs_irq[i]);
         rc(8'h14, 32'hF, {31'h0, cs_st[i]});
         wr(8'h14, 32'hF);
         ci(1'b1);
         rc(OFS_GIS, 32'hFFFFFFFF, 32'h0);
      end
      wr(8'h10, 32'h1F);
      ev(24'h010001);
      wr(8'h14, 32'h1);
      ci(1'b0);
      rc(OFS_GIS, 32'hFFFFFFFF, 32'h2);
      wr(8'h14, 32'h4);
      ci(1'b1);
      wr(OFS_GIE, 32'h8);
      wr(8'h20, 32'h31);
      ev(24'h4);
      ci(1'b1);
      ev(24'h400);
      ci(1'b0);
      rc(8'h24, 32'hF, 32'h1);
      wr(8'h24, 32'h1);
      wr(OFS_E0_CTL, 32'h1);
      u_host.setup(REQ_SET_CONFIG, 16'h0005, 16'h0000);
      ci(1'b0);
      rc(OFS_E0_STAT, 32'h0000FF07, 32'h00000501);
      wr(OFS_E0_STAT, 32'h1);
      ci(1'b1);
      wr(OFS_E0_CTL, 32'h0);
      u_host.dly = 7;
      u_host.setup(REQ_SET_INTF, 16'h0003, 16'h0002);
      repeat (10) @(posedge core_clk);
      ci(1'b1);
      rc(OFS_E0_STAT, 32'hFFFF0007, 32'h03020003);
      wr(OFS_E0_CTL, 32'h1);
      ci(1'b0);
      wr(OFS_E0_STAT, 32'h1);
      rc(OFS_E0_STAT, 32'h7, 32'h2);
      for (int i = 0; i < 3; i++) begin
         wr(OFS_E0_CTL, 32'h2);
         u_host.enter(1'b0);
         ci(1'b0);
         u_host.token();
         chk("status nak", {31'h0, last_nak}, 32'h1);
         wr(OFS_E0_STAT, 32'h4);
         ci(1'b1);
         rc(OFS_E0_CTL, 32'h2, 32'h0);
         u_host.token();
         chk("status ack", {31'h0, last_nak}, 32'h0);
      end
      u_host.enter(1'b0);
      rc(OFS_E0_STAT, 32'h4, 32'h0);
      wr(OFS_E0_CTL, 32'h2);
      u_host.enter(1'b1);
      rc(OFS_E0_STAT, 32'h4, 32'h0);
      results();
   end
endmodule
`default_nettype wire
